// *** common/afe_cfg_pkg.sv ***
/*
  Constants of the front-end configuration register bank: register
  addresses, field positions, reset values and decode limits.
  Assumes a 16-bit serial frame: two don't-care bits, four address bits, ten data bits.
*/
`default_nettype none
package afe_cfg_pkg;
  // ****************
  // Addresses
  // ****************
  localparam logic [3:0] ADDR_GENERAL = 4'h0;
  localparam logic [3:0] ADDR_GAIN = 4'h1;
  localparam logic [3:0] ADDR_LEVEL_ONE = 4'h2;
  localparam logic [3:0] ADDR_LEVEL_TWO = 4'h3;
  localparam logic [3:0] ADDR_BLACK = 4'h5;
  localparam logic [3:0] ADDR_INPUT_KIND = 4'h6;
  localparam logic [3:0] ADDR_DELAYS = 4'h8;
  localparam logic [3:0] ADDR_CLOCK_PINS = 4'h9;
  // ****************
  // Fields
  // ****************
  localparam int SOFT_RESET_BIT = 0;
  localparam int BLACK_ENABLE_BIT = 4;
  localparam int INPUT_KIND_BIT = 1;
  localparam int CONV_DELAY_LSB = 5;
  localparam int STROBE_PIN_BIT = 4;
  localparam int CONV_PIN_BIT = 3;
  localparam int LATCH_EDGE_BIT = 2;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_LSB = 10;
  // ****************
  // Reset values
  // ****************
  localparam logic [9:0] GAIN_RESET = 10'h000;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [4:0] BLACK_RESET = 5'h00;
  localparam logic INPUT_KIND_RESET = 1'b0;
  localparam logic [9:0] DELAYS_RESET = 10'h0e9;
  localparam logic [4:0] CLOCK_PINS_RESET = 5'h19;
  // ****************
  // Decode limits
  // ****************
  localparam logic [9:0] SENSOR_GAIN_MAX = 10'h2ff;
  localparam logic [9:0] VIDEO_GAIN_BASE = 10'h100;
  localparam logic [5:0] BLACK_LEVEL_BASE = 6'h14;
  localparam logic [2:0] STROBE_WIDTH_BASE = 3'h4;
endpackage : afe_cfg_pkg
`default_nettype wire

// *** rtl/afe_serial_rx.sv ***
/*
  Serial configuration receiver: gathers one 16-bit frame per chip-select
  window and presents address and data as a one-cycle write pulse.
  Assumes pins are asynchronous to clk and much slower than it.
*/
`default_nettype none
module afe_serial_rx (
  input wire logic clk,
  input wire logic resetn,
  input wire logic serialSelectN,
  input wire logic serialClock,
  input wire logic serialData,
  output logic writeValid,
  output logic [3:0] writeAddr,
  output logic [9:0] writeData
);
  typedef enum logic [0:0] {AFE_IDLE = 1'b0, AFE_SHIFT = 1'b1} afe_rx_state_t;

  logic [2:0] selMeta_reg;
  logic [2:0] clkMeta_reg;
  logic [1:0] datMeta_reg;
  logic [15:0] shift_reg;
  logic [4:0] count_reg;
  afe_rx_state_t state_reg;
  logic sclkRise;
  logic selRise;
  logic selFall;

  // ****************
  // Two-flop synchronisers, third stage only for edge detection
  // ****************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      selMeta_reg <= 3'h7;
      clkMeta_reg <= 3'h0;
      datMeta_reg <= 2'h0;
    end
    else
    begin
      selMeta_reg <= {selMeta_reg[1:0], serialSelectN};
      clkMeta_reg <= {clkMeta_reg[1:0], serialClock};
      datMeta_reg <= {datMeta_reg[0], serialData};
    end
  end

  assign sclkRise = clkMeta_reg[1] && !clkMeta_reg[2];
  assign selRise = selMeta_reg[1] && !selMeta_reg[2];
  assign selFall = !selMeta_reg[1] && selMeta_reg[2];

  // ****************
  // Frame capture
  // ****************
  // Count saturates past 16 so long or short frames are dropped whole
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= AFE_IDLE;
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
      writeValid <= 1'b0;
      writeAddr <= 4'h0;
      writeData <= 10'h000;
    end
    else
    begin
      writeValid <= 1'b0;
      case (state_reg)
        AFE_IDLE:
        begin
          if (selFall)
          begin
            state_reg <= AFE_SHIFT;
            count_reg <= 5'h00;
          end
        end
        AFE_SHIFT:
        begin
          if (selRise)
          begin
            state_reg <= AFE_IDLE;
            if (count_reg == 5'(afe_cfg_pkg::FRAME_BITS))
            begin
              writeValid <= 1'b1;
              writeAddr <= shift_reg[afe_cfg_pkg::ADDR_LSB +: 4];
              writeData <= shift_reg[9:0];
            end
          end
          else if (sclkRise)
          begin
            shift_reg <= {shift_reg[14:0], datMeta_reg[1]};
            if (count_reg <= 5'(afe_cfg_pkg::FRAME_BITS))
            begin
              count_reg <= count_reg + 5'h01;
            end
          end
        end
        default:
        begin
          state_reg <= AFE_IDLE;
        end
      endcase
    end
  end
endmodule : afe_serial_rx
`default_nettype wire

// *** rtl/afe_cfg_bank.sv ***
/*
  Configuration register bank of the imaging front end: holds the gain,
  user level, black level, input kind, delay and clock pin settings and
  drives their decoded control values.
  Assumes the host drives the serial port; analog circuits sit outside.
*/
`default_nettype none
module afe_cfg_bank (
  input wire logic clk,
  input wire logic resetn,
  input wire logic serialSelectN,
  input wire logic serialClock,
  input wire logic serialData,
  output logic [9:0] gainStep,
  output logic [7:0] user_level_out_one,
  output logic [7:0] user_level_out_two,
  output logic [5:0] black_level_output,
  output logic input_kind_select,
  output logic [4:0] conv_clock_delay_code,
  output logic [4:0] strobe_delay_code,
  output logic strobe_pin_disable,
  output logic conv_clock_pin_disable,
  output logic output_latch_edge_select,
  output logic [2:0] strobeWidthTwentieths
);
  logic writeValid;
  logic [3:0] writeAddr;
  logic [9:0] writeData;
  logic softReset;
  logic [9:0] gain_reg;
  logic [4:0] black_reg;
  logic [4:0] clockPins_reg;
  logic [9:0] gainStep_next;
  logic [5:0] blackLevel_next;

  afe_serial_rx u_rx (
    .clk(clk),
    .resetn(resetn),
    .serialSelectN(serialSelectN),
    .serialClock(serialClock),
    .serialData(serialData),
    .writeValid(writeValid),
    .writeAddr(writeAddr),
    .writeData(writeData)
  );

  // Other general-register bits belong to power control, not this bank
  assign softReset = writeValid && (writeAddr == afe_cfg_pkg::ADDR_GENERAL)
    && writeData[afe_cfg_pkg::SOFT_RESET_BIT];

  // ****************
  // Stored registers
  // ****************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gain_reg <= afe_cfg_pkg::GAIN_RESET;
      user_level_out_one <= afe_cfg_pkg::LEVEL_RESET;
      user_level_out_two <= afe_cfg_pkg::LEVEL_RESET;
      black_reg <= afe_cfg_pkg::BLACK_RESET;
      input_kind_select <= afe_cfg_pkg::INPUT_KIND_RESET;
      {conv_clock_delay_code, strobe_delay_code} <= afe_cfg_pkg::DELAYS_RESET;
      clockPins_reg <= afe_cfg_pkg::CLOCK_PINS_RESET;
    end
    else if (softReset)
    begin
      gain_reg <= afe_cfg_pkg::GAIN_RESET;
      user_level_out_one <= afe_cfg_pkg::LEVEL_RESET;
      user_level_out_two <= afe_cfg_pkg::LEVEL_RESET;
      black_reg <= afe_cfg_pkg::BLACK_RESET;
      input_kind_select <= afe_cfg_pkg::INPUT_KIND_RESET;
      {conv_clock_delay_code, strobe_delay_code} <= afe_cfg_pkg::DELAYS_RESET;
      clockPins_reg <= afe_cfg_pkg::CLOCK_PINS_RESET;
    end
    else if (writeValid)
    begin
      // Only defined bits are captured; reserved ones never reach a flop
      if (writeAddr == afe_cfg_pkg::ADDR_GAIN)
      begin
        gain_reg <= writeData;
      end
      else if (writeAddr == afe_cfg_pkg::ADDR_LEVEL_ONE)
      begin
        user_level_out_one <= writeData[7:0];
      end
      else if (writeAddr == afe_cfg_pkg::ADDR_LEVEL_TWO)
      begin
        user_level_out_two <= writeData[7:0];
      end
      else if (writeAddr == afe_cfg_pkg::ADDR_BLACK)
      begin
        black_reg <= writeData[4:0];
      end
      else if (writeAddr == afe_cfg_pkg::ADDR_INPUT_KIND)
      begin
        input_kind_select <= writeData[afe_cfg_pkg::INPUT_KIND_BIT];
      end
      else if (writeAddr == afe_cfg_pkg::ADDR_DELAYS)
      begin
        conv_clock_delay_code <= writeData[afe_cfg_pkg::CONV_DELAY_LSB +: 5];
        strobe_delay_code <= writeData[4:0];
      end
      else if (writeAddr == afe_cfg_pkg::ADDR_CLOCK_PINS)
      begin
        clockPins_reg <= writeData[4:0];
      end
    end
  end

  // ****************
  // Decoded controls
  // ****************
  always_comb
  begin
    if (!input_kind_select)
    begin
      // Out-of-range codes clamp rather than wrap
      gainStep_next = (gain_reg > afe_cfg_pkg::SENSOR_GAIN_MAX) ? afe_cfg_pkg::SENSOR_GAIN_MAX : gain_reg;
    end
    else if (gain_reg < afe_cfg_pkg::VIDEO_GAIN_BASE)
    begin
      gainStep_next = 10'h000;
    end
    else
    begin
      // Codes above 767 clamp to the 24 dB step
      gainStep_next = ((gain_reg > afe_cfg_pkg::SENSOR_GAIN_MAX) ? afe_cfg_pkg::SENSOR_GAIN_MAX : gain_reg)
        - afe_cfg_pkg::VIDEO_GAIN_BASE;
    end
    if (black_reg[afe_cfg_pkg::BLACK_ENABLE_BIT])
    begin
      blackLevel_next = afe_cfg_pkg::BLACK_LEVEL_BASE + {2'h0, black_reg[3:0]};
    end
    else
    begin
      blackLevel_next = 6'h00;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // Reset values are the decode of the register defaults
      gainStep <= afe_cfg_pkg::GAIN_RESET;
      black_level_output <= 6'h00;
      strobe_pin_disable <= afe_cfg_pkg::CLOCK_PINS_RESET[afe_cfg_pkg::STROBE_PIN_BIT];
      conv_clock_pin_disable <= afe_cfg_pkg::CLOCK_PINS_RESET[afe_cfg_pkg::CONV_PIN_BIT];
      output_latch_edge_select <= afe_cfg_pkg::CLOCK_PINS_RESET[afe_cfg_pkg::LATCH_EDGE_BIT];
      strobeWidthTwentieths <= afe_cfg_pkg::STROBE_WIDTH_BASE + {1'b0, afe_cfg_pkg::CLOCK_PINS_RESET[1:0]};
    end
    else
    begin
      gainStep <= gainStep_next;
      black_level_output <= blackLevel_next;
      strobe_pin_disable <= clockPins_reg[afe_cfg_pkg::STROBE_PIN_BIT];
      conv_clock_pin_disable <= clockPins_reg[afe_cfg_pkg::CONV_PIN_BIT];
      output_latch_edge_select <= clockPins_reg[afe_cfg_pkg::LATCH_EDGE_BIT];
      strobeWidthTwentieths <= afe_cfg_pkg::STROBE_WIDTH_BASE + {1'b0, clockPins_reg[1:0]};
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  gain_saturates_a: assert property (!input_kind_select && gain_reg > 10'h2ff |=> gainStep == 10'h2ff)
    else $error("sensor gain did not saturate at 767");
  sensor_linear_a: assert property (!input_kind_select && gain_reg <= 10'h2ff |=> gainStep == $past(gain_reg))
    else $error("sensor gain step differs from code");
  video_offset_a: assert property (input_kind_select && gain_reg >= 10'h100 && gain_reg <= 10'h2ff
    |=> gainStep == $past(gain_reg) - 10'h100)
    else $error("video gain step not code minus 256");
  video_high_a: assert property (input_kind_select && gain_reg == 10'h2ff |=> gainStep == 10'h1ff)
    else $error("video code 767 not at 24 dB step");
  black_off_a: assert property (!black_reg[4] |=> black_level_output == 6'h00)
    else $error("black level output nonzero while disabled");
  black_on_a: assert property (black_reg[4] |=> black_level_output == 6'h14 + {2'h0, $past(black_reg[3:0])})
    else $error("black level output wrong while enabled");
  soft_reset_a: assert property (softReset |=> gain_reg == 10'h000 && {conv_clock_delay_code, strobe_delay_code}
    == 10'h0e9 ##1 strobe_pin_disable && conv_clock_pin_disable && strobeWidthTwentieths == 3'h5)
    else $error("soft reset did not restore defaults");
  gain_write_a: assert property (writeValid && writeAddr == 4'h1 && !softReset |=> gain_reg == $past(writeData))
    else $error("gain write not stored");
  kind_write_a: assert property (writeValid && writeAddr == 4'h6 |=> input_kind_select == $past(writeData[1]))
    else $error("input kind not taken from bit D1");
  hold_value_a: assert property (!writeValid |=> $stable(gain_reg) && $stable(black_reg) && $stable(clockPins_reg))
    else $error("register changed without a write");
  delay_write_a: assert property (writeValid && writeAddr == 4'h8 |=> conv_clock_delay_code == $past(writeData[9:5])
    && strobe_delay_code == $past(writeData[4:0]))
    else $error("delay fields not split at D5");
  pins_follow_a: assert property (writeValid && writeAddr == 4'h9 |=> ##1 strobe_pin_disable == $past(writeData[4], 2)
    && output_latch_edge_select == $past(writeData[2], 2))
    else $error("clock control bits not decoded");
  // Write paths: each register keeps only its defined bits
  level_one_a: assert property (writeValid && writeAddr == 4'h2
    |=> user_level_out_one == $past(writeData[7:0]))
    else $error("level one write not stored");
  level_two_a: assert property (writeValid && writeAddr == 4'h3
    |=> user_level_out_two == $past(writeData[7:0]))
    else $error("level two write not stored");
  black_write_a: assert property (writeValid && writeAddr == 4'h5 |=> black_reg == $past(writeData[4:0]))
    else $error("black level write not stored");
  pins_width_a: assert property (writeValid && writeAddr == 4'h9 |=> ##1
    conv_clock_pin_disable == $past(writeData[3], 2)
    && strobeWidthTwentieths == 3'h4 + {1'b0, $past(writeData[1:0], 2)})
    else $error("conversion pin or strobe width not decoded");
  unmapped_addr_a: assert property (writeValid && (writeAddr == 4'h4 || writeAddr == 4'h7)
    |=> $stable(gain_reg) && $stable(black_reg) && $stable(clockPins_reg) && $stable(user_level_out_one))
    else $error("write to unmapped address changed a register");

  // ****************
  // Cover points
  // ****************
  cover_video_c: cover property (writeValid && writeAddr == 4'h6 && writeData[1]);
  cover_soft_c: cover property (softReset);
  cover_black_c: cover property (black_level_output == 6'h23);
  cover_sat_c: cover property (gainStep == 10'h2ff);
  cover_pins_c: cover property (strobeWidthTwentieths == 3'h7 && !strobe_pin_disable);
endmodule : afe_cfg_bank
`default_nettype wire

// *** sim/afe_host_model.sv ***
/*
  Host side of the serial configuration port: frames of up to 16 bits, MSB first.
  Assumes the caller enters send just after a falling edge of clk.
*/
`default_nettype none
module afe_host_model (
  input wire logic clk,
  output logic serialSelectN,
  output logic serialClock,
  output logic serialData
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Idle levels
  // ****************
  initial
  begin
    serialSelectN = 1'b1;
    serialClock = 1'b0;
    serialData = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // ****************
  // Frame
  // ****************
  // Four cycles per level: one above what the synchroniser needs
  task automatic send(input logic [15:0] frame, input int nBits);
    serialSelectN = 1'b0;
    hold(4);
    for (int i = 15; i > 15 - nBits; i--)
    begin
      serialData = frame[i];
      hold(4);
      serialClock = 1'b1;
      hold(4);
      serialClock = 1'b0;
    end
    hold(4);
    serialSelectN = 1'b1;
    // Released data line must not keep its last bit
    serialData = ~serialData;
    hold(4);
  endtask : send
endmodule : afe_host_model
`default_nettype wire

// *** sim/tb_afe_config_register_bank.sv ***
/*
  Self-checking bench of the configuration register bank: corner and random writes.
  Assumes the host model for the serial pins and 250 MHz clock.
*/
`default_nettype none
module tb_afe_config_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic selN, sClk, sDat, kindSel, strobeOff, convOff, latchEdge;
  logic [9:0] gainStep;
  logic [7:0] lvlOne, lvlTwo;
  logic [5:0] blackOut;
  logic [4:0] convDelay, strobeDelay;
  logic [2:0] width;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'hee4fca74;
  logic [9:0] gainR, dlyR;
  logic [7:0] lvl1R, lvl2R;
  logic [4:0] blkR, ckR;
  logic kindR;
  logic [9:0] corner [7] = '{10'h000, 10'h0ff, 10'h100, 10'h200, 10'h201, 10'h2ff, 10'h300};
  always #2 clk = ~clk;
  afe_host_model host_u (.clk(clk), .serialSelectN(selN), .serialClock(sClk), .serialData(sDat));
  afe_cfg_bank dut_u (.clk(clk), .resetn(resetn), .serialSelectN(selN), .serialClock(sClk),
    .serialData(sDat), .gainStep(gainStep), .user_level_out_one(lvlOne), .user_level_out_two(lvlTwo),
    .black_level_output(blackOut), .input_kind_select(kindSel), .conv_clock_delay_code(convDelay),
    .strobe_delay_code(strobeDelay), .strobe_pin_disable(strobeOff), .conv_clock_pin_disable(convOff),
    .output_latch_edge_select(latchEdge), .strobeWidthTwentieths(width));
  // ****************
  // Checking
  // ****************
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  function automatic logic [9:0] expGain(input logic [9:0] g, input logic k);
    if (!k)
      return (g > 10'h2ff) ? 10'h2ff : g;
    if (g < 10'h100)
      return 10'h000;
    return (g > 10'h2ff) ? 10'h1ff : g - 10'h100;
  endfunction : expGain
  task automatic defaults();
    gainR = 10'h000;
    lvl1R = 8'h00;
    lvl2R = 8'h00;
    blkR = 5'h00;
    kindR = 1'b0;
    dlyR = 10'h0e9;
    ckR = 5'h19;
  endtask : defaults
  task automatic check_all();
    check(gainStep, expGain(gainR, kindR));
    check(10'(lvlOne), 10'(lvl1R));
    check(10'(lvlTwo), 10'(lvl2R));
    check(10'(blackOut), blkR[4] ? 10'h014 + 10'(blkR[3:0]) : 10'h000);
    check(10'(kindSel), 10'(kindR));
    check(10'(convDelay), 10'(dlyR[9:5]));
    check(10'(strobeDelay), 10'(dlyR[4:0]));
    check(10'(strobeOff), 10'(ckR[4]));
    check(10'(convOff), 10'(ckR[3]));
    check(10'(latchEdge), 10'(ckR[2]));
    check(10'(width), 10'h004 + 10'(ckR[1:0]));
  endtask : check_all
  // Don't-care frame bits set high so a wrong address slice shows
  task automatic write(input logic [3:0] a, input logic [9:0] d);
    host_u.send({2'b11, a, d}, 16);
    case (a)
      4'h0: if (d[0]) defaults();
      4'h1: gainR = d;
      4'h2: lvl1R = d[7:0];
      4'h3: lvl2R = d[7:0];
      4'h5: blkR = d[4:0];
      4'h6: kindR = d[1];
      4'h8: dlyR = d;
      4'h9: ckR = d[4:0];
      default: ;
    endcase
    repeat (8) @(negedge clk);
    check_all();
  endtask : write
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // ****************
  // Sequence
  // ****************
  initial
  begin : main
    logic [3:0] a;
    logic [9:0] d;
    defaults();
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    check_all();
    for (int k = 0; k < 2; k++)
    begin
      write(4'h6, {8'h00, k[0], 1'b0});
      foreach (corner[j])
        write(4'h1, corner[j]);
    end
    // Short frame must leave every register alone
    host_u.send({2'b00, 4'h1, 10'h155}, 15);
    repeat (8) @(negedge clk);
    check_all();
    write(4'h0, 10'h3fe);
    write(4'h9, 10'h3e7);
    write(4'h8, 10'h3bd);
    write(4'h7, 10'h3ff);
    for (int i = 0; i < 40; i++)
    begin
      a = 4'h1 + 4'(unsigned'($random(seed)) % 10);
      d = 10'($random(seed));
      if (a == 4'h1)
        d = kindR ? 10'h100 + (d % 10'h101) : d % 10'h300;
      if (a == 4'h6)
        d[0] = 1'b0;
      if (a == 4'h8)
      begin
        d[9:5] = (d[9:5] > 5'h1d) ? 5'h1d : d[9:5];
        d[4:0] = (d[4:0] > 5'h1d) ? 5'h1d : d[4:0];
      end
      write(a, d);
    end
    write(4'h0, 10'h001);
    write(4'h5, 10'h3ff);
    resetn = 1'b0;
    defaults();
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    check_all();
    results();
  end
  initial
  begin : watchdog
    #100us;
    err_total++;
    results();
  end
endmodule : tb_afe_config_register_bank
`default_nettype wire
